/* design/slf_pkg.sv */
// package: register map, fields and reset values for the loop filter block
// Contract
// - six-bit third-pole resistor code at bits 6:1, resets zero, nonvolatile backed
// - bit 0 selects integer (0) or fractional (1) filter, resets 0
// - three-bit third-pole capacitor code at bits 2:0, resets zero, 5 pF per step
// - post-divider select bits 4:2: codes 0,1 divide 2, codes 2..7 divide 3..8
// - resync enable bit 1, reset 1, lets sync event resync synth2 channels
// - power-down bit 0, reset 0, enables synth2 and calibration after reset
// - writing 1 to power-down disables synth2 and holds calibration reset
// - clearing power-down re-enables synth2 and restarts calibration
package slf_pkg;
  // ****************
  // register indices
  // ****************
  localparam logic [7:0] SLF_IDX_R3 = 8'h45;
  localparam logic [7:0] SLF_IDX_C3 = 8'h46;
  localparam logic [7:0] SLF_IDX_CTRL0 = 8'h47;
  localparam int SLF_WORD_SHIFT = 2;
  // ****************
  // fields and resets
  // ****************
  localparam logic [7:0] SLF_R3_MASK = 8'h7f;
  localparam logic [7:0] SLF_C3_MASK = 8'h07;
  localparam logic [7:0] SLF_CTRL0_MASK = 8'h1f;
  localparam logic [7:0] SLF_R3_RESET = 8'h00;
  localparam logic [7:0] SLF_C3_RESET = 8'h00;
  localparam logic [7:0] SLF_CTRL0_RESET = 8'h1e;
  localparam logic [3:0] SLF_DIV_MIN = 4'h2;
  localparam logic [3:0] SLF_DIV_OFS = 4'h1;
  localparam logic [2:0] SLF_P_FIRST_STEP = 3'h2;
  localparam logic [6:0] SLF_CAP_STEP_PF = 7'h05;
  localparam logic [31:0] SLF_HRESP_OKAY = 32'h0000_0000;
  localparam logic [1:0] SLF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] SLF_HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic [5:0] resistor_code;
    logic fractional_select;
  } slf_r3_t;

  typedef struct packed {
    logic [2:0] post_divider_select;
    logic resync_enable;
    logic power_down;
  } slf_ctrl0_t;

  typedef struct packed {
    logic synth2_enable;
    logic calib_reset;
    logic calib_start;
  } slf_synth2_t;

  typedef enum logic [1:0] {
    SLF_RUN = 2'b00,
    SLF_DOWN = 2'b01,
    SLF_RESTART = 2'b10
  } slf_pwr_state_t;

  // divide ratio from post-divider code
  function automatic logic [3:0] slf_post_ratio(input logic [2:0] code);
    if (code < SLF_P_FIRST_STEP) begin
      slf_post_ratio = SLF_DIV_MIN;
    end else begin
      slf_post_ratio = {1'b0, code} + SLF_DIV_OFS;
    end
  endfunction
endpackage

/* design/slf_power_seq.sv */
// module: synth2 power-down and calibration restart sequencer
`timescale 1ns/1ps
`default_nettype none
module slf_power_seq
  import slf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic power_down,
  output slf_synth2_t synth2
);
  slf_pwr_state_t state;
  slf_pwr_state_t next_state;
  slf_synth2_t next_synth2;

  always_comb begin
    next_state = state;
    case (state)
      SLF_RUN: begin
        if (power_down) begin
          next_state = SLF_DOWN;
        end
      end
      SLF_DOWN: begin
        if (!power_down) begin
          next_state = SLF_RESTART;
        end
      end
      SLF_RESTART: begin
        next_state = power_down ? SLF_DOWN : SLF_RUN;
      end
      default: begin
        next_state = SLF_RUN;
      end
    endcase
    next_synth2.synth2_enable = (next_state != SLF_DOWN);
    next_synth2.calib_reset = (next_state == SLF_DOWN);
    next_synth2.calib_start = (next_state == SLF_RESTART);
  end

  // after reset synth2 enabled and calibration launched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SLF_RESTART;
      synth2 <= 3'b101;
    end else begin
      state <= next_state;
      synth2 <= next_synth2;
    end
  end

  pwr_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
    power_down |=> (synth2.calib_reset && !synth2.synth2_enable))
    else $error("power-down did not stop synth2");
  calib_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    synth2.calib_start |=> !synth2.calib_start)
    else $error("calibration start longer than one cycle");
  restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(power_down) |=> synth2.calib_start && synth2.synth2_enable)
    else $error("calibration not restarted");
  cv_restart_c: cover property (@(posedge hclk) disable iff (!hresetn)
    synth2.calib_start ##1 synth2.synth2_enable);
endmodule
`default_nettype wire

/* design/slf_regs.sv */
// module: AHB-Lite slave for the loop filter and synth2 control registers
`timescale 1ns/1ps
`default_nettype none
module slf_regs
  import slf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic sync_event,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [5:0] synth1_third_pole_resistor_code,
  output logic synth1_filter_fractional_select,
  output logic [2:0] synth1_third_pole_capacitor_code,
  output logic [6:0] synth1_capacitance_pf,
  output logic [3:0] synth2_post_ratio,
  output logic synth2_resync,
  output logic synth2_enable,
  output logic synth2_calib_reset,
  output logic synth2_calib_start
);
  // ****************
  // registers
  // ****************
  slf_r3_t r3;
  logic [2:0] c3;
  slf_ctrl0_t ctrl0;
  slf_r3_t next_r3;
  logic [2:0] next_c3;
  slf_ctrl0_t next_ctrl0;
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] next_wr_idx;
  logic [31:0] next_hrdata;
  logic sync_q1;
  logic sync_q2;
  logic sync_q3;
  logic next_resync;
  logic [6:0] next_cap;
  logic [3:0] next_ratio;
  logic [7:0] a_idx;
  logic take;
  slf_synth2_t synth2;
  localparam logic [3:0] SLF_RATIO_RESET = 4'h8;

  // ****************
  // bus decode
  // ****************
  function automatic logic [7:0] slf_rd(input logic [7:0] idx,
      input slf_r3_t r, input logic [2:0] c, input slf_ctrl0_t k);
    case (idx)
      SLF_IDX_R3: slf_rd = {1'b0, r} & SLF_R3_MASK;
      SLF_IDX_C3: slf_rd = {5'h00, c} & SLF_C3_MASK;
      SLF_IDX_CTRL0: slf_rd = {3'h0, k} & SLF_CTRL0_MASK;
      default: slf_rd = 8'h00;
    endcase
  endfunction

  assign a_idx = haddr[SLF_WORD_SHIFT +: 8];
  assign take = hsel && hready &&
    (htrans == SLF_HTRANS_NONSEQ || htrans == SLF_HTRANS_SEQ);

  always_comb begin
    next_r3 = r3;
    next_c3 = c3;
    next_ctrl0 = ctrl0;
    next_wr_pend = take && hwrite;
    next_wr_idx = take ? a_idx : wr_idx;
    next_hrdata = 32'h0000_0000;
    if (wr_pend) begin
      case (wr_idx)
        SLF_IDX_R3: next_r3 = hwdata[6:0];
        SLF_IDX_C3: next_c3 = hwdata[2:0];
        SLF_IDX_CTRL0: next_ctrl0 = hwdata[4:0];
        default: next_r3 = r3;
      endcase
    end
    if (take && !hwrite) begin
      next_hrdata = {24'h00_0000, slf_rd(a_idx, next_r3, next_c3,
        next_ctrl0)};
    end
    next_resync = sync_q2 && !sync_q3 && ctrl0.resync_enable;
    next_cap = 7'(c3 * SLF_CAP_STEP_PF);
    next_ratio = slf_post_ratio(ctrl0.post_divider_select);
  end

  // resets match nonvolatile defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r3 <= SLF_R3_RESET[6:0];
      c3 <= SLF_C3_RESET[2:0];
      ctrl0 <= SLF_CTRL0_RESET[4:0];
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      sync_q1 <= 1'b0;
      sync_q2 <= 1'b0;
      sync_q3 <= 1'b0;
      synth2_resync <= 1'b0;
      synth1_capacitance_pf <= 7'h00;
      synth2_post_ratio <= SLF_RATIO_RESET;
    end else begin
      r3 <= next_r3;
      c3 <= next_c3;
      ctrl0 <= next_ctrl0;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= SLF_HRESP_OKAY[0];
      sync_q1 <= sync_event;
      sync_q2 <= sync_q1;
      sync_q3 <= sync_q2;
      synth2_resync <= next_resync;
      synth1_capacitance_pf <= next_cap;
      synth2_post_ratio <= next_ratio;
    end
  end

  assign synth1_third_pole_resistor_code = r3.resistor_code;
  assign synth1_filter_fractional_select = r3.fractional_select;
  assign synth1_third_pole_capacitor_code = c3;
  assign synth2_enable = synth2.synth2_enable;
  assign synth2_calib_reset = synth2.calib_reset;
  assign synth2_calib_start = synth2.calib_start;

  slf_power_seq u_power (
    .hclk(hclk),
    .hresetn(hresetn),
    .power_down(ctrl0.power_down),
    .synth2(synth2)
  );

  // ****************
  // checks
  // ****************
  cap_scale_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 synth1_capacitance_pf == 7'($past(c3) * SLF_CAP_STEP_PF))
    else $error("capacitance not five pF per code");
  ratio_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ($past(ctrl0.post_divider_select) < 3'h2 ?
    synth2_post_ratio == 4'h2 :
    synth2_post_ratio == {1'b0, $past(ctrl0.post_divider_select)} + 4'h1))
    else $error("post-divider ratio wrong");
  resync_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    synth2_resync |-> $past(ctrl0.resync_enable))
    else $error("resync without enable");
  r3_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == SLF_IDX_R3 |=> r3 == $past(hwdata[6:0]))
    else $error("resistor register not written");
  ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == SLF_IDX_CTRL0 |=> ctrl0 == $past(hwdata[4:0]))
    else $error("synth2 control not written");
  rsvd_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:7] == 25'h0)
    else $error("reserved bits read nonzero");
  c3_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && a_idx == SLF_IDX_C3 |=> hrdata[7:3] == 5'h00)
    else $error("capacitor reserved bits nonzero");
  frac_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && a_idx == SLF_IDX_R3 && !wr_pend
    |=> hrdata[0] == $past(r3.fractional_select))
    else $error("filter select readback wrong");
  c3_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == SLF_IDX_C3 |=> c3 == $past(hwdata[2:0]))
    else $error("capacitor register not written");
  r3_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend && wr_idx == SLF_IDX_R3) |=> $stable(r3))
    else $error("resistor register changed without write");
  ctrl_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend && wr_idx == SLF_IDX_CTRL0) |=> $stable(ctrl0))
    else $error("synth2 control changed without write");
  r3_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && a_idx == SLF_IDX_R3 && !wr_pend
    |=> hrdata[7:0] == {1'b0, $past(r3)})
    else $error("resistor readback wrong");
  ctrl_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && a_idx == SLF_IDX_CTRL0 && !wr_pend
    |=> hrdata[7:0] == {3'h0, $past(ctrl0)})
    else $error("synth2 control readback wrong");
  unmap_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && a_idx != SLF_IDX_R3 && a_idx != SLF_IDX_C3 &&
    a_idx != SLF_IDX_CTRL0 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read nonzero");
  idle_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(take && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus not ready or not okay");
  resync_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    synth2_resync |=> !synth2_resync)
    else $error("resync longer than one cycle");
  boot_en_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl0.power_down ##1 !ctrl0.power_down |-> synth2_enable)
    else $error("synth2 not enabled while powered");
  cv_write_c: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_idx == SLF_IDX_C3);
  cv_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && a_idx == SLF_IDX_CTRL0);
  cv_resync_c: cover property (@(posedge hclk) disable iff (!hresetn)
    synth2_resync);
endmodule
`default_nettype wire

/* sim/tb.sv */
// testbench: register access, field decode, sync and power sequencing
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****************
  // signals
  // ****************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic sync_event = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, fsel, rsync, en, creset, cstart;
  logic [5:0] r3c;
  logic [2:0] c3c;
  logic [6:0] cap;
  logic [3:0] ratio;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cnt;
  localparam logic [31:0] A_R3 = 32'h0000_0114;
  localparam logic [31:0] A_C3 = 32'h0000_0118;
  localparam logic [31:0] A_K0 = 32'h0000_011c;

  always #10 hclk = ~hclk;

  slf_regs slf_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .sync_event(sync_event),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .synth1_third_pole_resistor_code(r3c),
    .synth1_filter_fractional_select(fsel),
    .synth1_third_pole_capacitor_code(c3c), .synth1_capacitance_pf(cap),
    .synth2_post_ratio(ratio), .synth2_resync(rsync), .synth2_enable(en),
    .synth2_calib_reset(creset), .synth2_calib_start(cstart));

  // ****************
  // helpers
  // ****************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask

  task rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  task settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  // ****************
  // scenarios
  // ****************
  task t_reset;
    rdchk("r3 rst", A_R3, 32'h0000_0000);
    rdchk("c3 rst", A_C3, 32'h0000_0000);
    rdchk("k0 rst", A_K0, 32'h0000_001e);
    chk("ratio rst", {28'h0, ratio}, 32'h0000_0008);
    chk("en rst", {31'h0, en}, 32'h0000_0001);
  endtask

  task t_r3;
    bus(1'b1, A_R3, 32'hffff_ffff);
    rdchk("r3 rb", A_R3, 32'h0000_007f);
    settle;
    chk("r3 code", {26'h0, r3c}, 32'h0000_003f);
    chk("frac 1", {31'h0, fsel}, 32'h0000_0001);
    bus(1'b1, A_R3, 32'h0000_0054);
    settle;
    chk("r3 code2", {26'h0, r3c}, 32'h0000_002a);
    chk("frac 0", {31'h0, fsel}, 32'h0000_0000);
  endtask

  task t_c3;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, A_C3, {24'h0000_00, 5'h1f, 3'(i)});
      rdchk("c3 rb", A_C3, 32'(i));
      settle;
      chk("c3 code", {29'h0, c3c}, 32'(i));
      chk("cap", {25'h0, cap}, 32'(5 * i));
    end
  endtask

  task t_div;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, A_K0, {24'h0000_00, 3'h7, 3'(i), 2'b10});
      rdchk("k0 rb", A_K0, {24'h0, 3'h0, 3'(i), 2'b10});
      settle;
      chk("ratio", 32'(ratio), (i < 2) ? 32'd2 : 32'(i + 1));
    end
  endtask

  task sync_try(input logic [31:0] k0, input logic [31:0] exp);
    bus(1'b1, A_K0, k0);
    @(posedge hclk);
    sync_event <= 1'b1;
    cnt = 0;
    repeat (8) begin
      @(posedge hclk);
      #1;
      cnt += rsync;
    end
    @(posedge hclk);
    sync_event <= 1'b0;
    chk("resync", 32'(cnt), exp);
    repeat (8) @(posedge hclk);
  endtask

  task t_pwr;
    bus(1'b1, A_K0, 32'h0000_001f);
    settle;
    chk("en off", {31'h0, en}, 32'h0000_0000);
    chk("cal hold", {31'h0, creset}, 32'h0000_0001);
    bus(1'b1, A_K0, 32'h0000_001e);
    cnt = 0;
    repeat (6) begin
      @(posedge hclk);
      #1;
      cnt += cstart;
    end
    chk("cal start", 32'(cnt), 32'h0000_0001);
    chk("en on", {31'h0, en}, 32'h0000_0001);
    chk("cal free", {31'h0, creset}, 32'h0000_0000);
  endtask

  task t_unmap;
    bus(1'b1, 32'h0000_0000, 32'hffff_ffff);
    rdchk("unmapped", 32'h0000_0000, 32'h0000_0000);
    rdchk("r3 kept", A_R3, 32'h0000_0054);
  endtask

  task wrap_up;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************
  // sequence
  // ****************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_r3;
    t_c3;
    t_div;
    sync_try(32'h0000_001e, 32'h0000_0001);
    sync_try(32'h0000_001c, 32'h0000_0000);
    t_pwr;
    t_unmap;
    wrap_up;
  end

  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
endmodule
`default_nettype wire
